/* dv/dbwu_top_sva.sv */
// Checker for dbwu_top: bus answer, hit pulse and interrupt line relations.
// Assumes it is bound to dbwu_top and sees only its ports.
`timescale 1ns/100ps

module dbwu_top_sva (
   input wire logic        SYS_CLK,
   input wire logic        RESET_N,
   input wire logic        HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0]  HTRANS,
   input wire logic        HWRITE,
   input wire logic        HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic        HREADYOUT,
   input wire logic        HRESP,
   input wire logic        FETCH_VALID,
   input wire logic        MEM_VALID,
   input wire logic        RES_VALID,
   input wire logic        DEBUG_TRIGGER,
   input wire logic        IRQ
);
   logic armed;
   wire  take    = HSEL && HREADY && HTRANS == 2'h2;
   wire  wr_take = take && HWRITE;
   wire  rd_take = take && !HWRITE;
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   // ************************************************************
   // Helpers
   // ************************************************************
   // Nothing can be armed before the first write is taken
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         armed <= 1'h0;
      end else if (wr_take) begin
         armed <= 1'h1;
      end
   end
   sequence s_quiet; !FETCH_VALID && !MEM_VALID && !RES_VALID; endsequence
   // Register written two edges back, so its data phase has just landed
   sequence s_wr_done; $past(wr_take, 2); endsequence
   // ************************************************************
   // Assertions
   // ************************************************************
   a_ready_high: assert property (HREADYOUT) else $error("wait state seen");
   a_resp_okay: assert property (!HRESP) else $error("error response seen");
   a_quiet_no_hit: assert property (s_quiet |=> !DEBUG_TRIGGER)
      else $error("trigger without a report");
   a_reset_disarmed: assert property (!armed |-> !DEBUG_TRIGGER)
      else $error("trigger before any setup");
   a_irq_rise_cause: assert property ($rose(IRQ) |-> DEBUG_TRIGGER or s_wr_done)
      else $error("interrupt rose without cause");
   a_irq_fall_write: assert property ($fell(IRQ) |-> s_wr_done) else $error("interrupt fell on its own");
   a_rdata_hold: assert property (!$past(rd_take) |-> $stable(HRDATA)) else $error("read data moved");
   a_unmapped_zero: assert property (rd_take && HADDR[31:10] != 22'h0 |=> HRDATA == 32'h0)
      else $error("unmapped read not zero");
endmodule // dbwu_top_sva

/* dv/tb.sv */
// Self-checking bench for dbwu_top: register file, three hit kinds, interrupt.
// Assumes one zero-wait slave, so HREADY is looped back from HREADYOUT.
`timescale 1ns/100ps

module tb;
   import dbwu_pkg::*;
   logic        sys_clk, reset_n, hsel, hwrite, fv, mv, ml, rv, rd_ph;
   logic [1:0]  htrans;
   logic [2:0]  ft, mt, rt;
   logic [31:0] haddr, hwdata, pc, ma, rid, r, a;
   wire  [31:0] hrdata;
   wire         hready, hresp, dbg, irq;
   int          err_total, cmp_count;
   logic [31:0] exp_q[$];
   int          trig_q[$];
   logic [7:0]  base[8] = '{8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'h90, 8'h9C};
   logic [31:0] wm[8] = '{'1, DBWU_IB_CTRL_WMASK, '1, '1, DBWU_DW_CTRL_WMASK, '1, '1, DBWU_RW_CTRL_WMASK};

   dbwu_top i_dbwu_top (.SYS_CLK(sys_clk), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
      .HRESP(hresp), .FETCH_VALID(fv), .FETCH_PC(pc), .FETCH_THREAD(ft), .MEM_VALID(mv), .MEM_ADDR(ma),
      .MEM_LOAD(ml), .MEM_THREAD(mt), .RES_VALID(rv), .RES_ID(rid), .RES_THREAD(rt), .DEBUG_TRIGGER(dbg),
      .IRQ(irq));

   function automatic logic [31:0] ad(input logic [7:0] i);
      return {22'h0, i, 2'h0};
   endfunction
   task automatic conclude;
      if (err_total == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic fail(input string m);
      err_total++;
      $display("[ERR] %0t %s", $time, m);
   endtask
   task automatic cmp32(input logic [31:0] g, e);
      cmp_count++;
      if (g !== e) fail($sformatf("got %h expected %h", g, e));
   endtask
   task automatic chk_irq(input logic e);
      @(negedge sys_clk);
      cmp32({31'h0, irq}, {31'h0, e});
   endtask
   // Bounded wait for hready at a rising edge
   task automatic waitrdy;
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fail("bus hang");
         conclude();
      end
   endtask
   task automatic bus(input logic [31:0] ad_, d, input logic w);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= ad_;
      waitrdy();
      htrans <= 2'h0;
      hwdata <= d;
      rd_ph <= !w;
      waitrdy();
      hsel <= 1'b0;
      rd_ph <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] ad_, d);
      bus(ad_, d, 1'b1);
   endtask
   task automatic rd(input logic [31:0] ad_, e);
      exp_q.push_back(e);
      bus(ad_, 32'h0, 1'b0);
   endtask
   // One core report of kind k (0 fetch, 1 memory, 2 resource), n triggers expected
   task automatic hit(input int k, input logic [31:0] v, input logic [2:0] t, input logic ld, input int n);
      repeat (n) trig_q.push_back(1);
      @(posedge sys_clk);
      fv <= k == 0;
      mv <= k == 1;
      rv <= k == 2;
      ml <= ld;
      {pc, ma, rid} <= {v, v, v};
      {ft, mt, rt} <= {t, t, t};
      @(posedge sys_clk);
      {fv, mv, rv} <= 3'h0;
      repeat (2) @(posedge sys_clk);
      cmp32(trig_q.size(), 0);
   endtask

   // ************************************************************
   // Result watchers
   // ************************************************************
   always @(posedge sys_clk) begin
      if (rd_ph && hready) cmp32(hrdata, exp_q.pop_front());
      if (dbg === 1'b1) begin
         cmp_count++;
         if (trig_q.size() == 0) fail("unexpected trigger");
         else void'(trig_q.pop_front());
      end
   end
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      #500000;
      fail("run timeout");
      conclude();
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      {reset_n, hsel, hwrite, fv, mv, ml, rv, rd_ph, htrans, ft, mt, rt} = '0;
      {haddr, hwdata, pc, ma, rid} = '0;
      err_total = 0;
      cmp_count = 0;
      r = $urandom(1261);
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'b1;
      foreach (base[b]) for (int u = 0; u < 4; u++) begin
         rd(ad(base[b] + 8'(u)), 32'h0);
         r = $urandom;
         wr(ad(base[b] + 8'(u)), r);
         rd(ad(base[b] + 8'(u)), r & wm[b]);
         wr(ad(base[b] + 8'(u)), 32'h0);
      end
      wr(32'h0001_0100, 32'h00FF_0001);
      rd(32'h0001_0100, 32'h0);
      rd(ad(8'h40), 32'h0);
      a = $urandom & 32'hFFFF_FFFC;
      wr(ad(8'h31), a);
      wr(ad(8'h33), a);
      wr(ad(8'h41), 32'h0020_0001);
      wr(ad(8'h43), 32'h0020_0001);
      hit(0, a, 3'h3, 1'b0, 0);
      hit(0, a, 3'h5, 1'b0, 1);
      rd(ad(8'h15), 32'h0001_0503);
      wr(ad(8'h41), 32'h0020_0003);
      wr(ad(8'h43), 32'h0);
      hit(0, a, 3'h5, 1'b0, 0);
      hit(0, a + 4, 3'h5, 1'b0, 1);
      wr(ad(8'h41), 32'h0);
      wr(ad(8'h52), a);
      wr(ad(8'h62), a + 8);
      wr(ad(8'h72), 32'h00FF_0001);
      hit(1, a, 3'h2, 1'b0, 0);
      wr(ad(8'h72), 32'h00FF_0003);
      hit(1, a + 8, 3'h2, 1'b0, 1);
      rd(ad(8'h15), 32'h0002_0204);
      rd(ad(8'h16), a + 8);
      hit(1, a, 3'h2, 1'b1, 0);
      wr(ad(8'h72), 32'h00FF_0007);
      hit(1, a, 3'h2, 1'b1, 1);
      wr(ad(8'h72), 32'h0);
      wr(ad(8'h83), 32'h0000_00FF);
      wr(ad(8'h93), 32'h0000_002A);
      wr(ad(8'h9F), 32'h0080_0001);
      hit(2, 32'h1234_562A, 3'h7, 1'b0, 1);
      rd(ad(8'h15), 32'h0003_0705);
      rd(ad(8'h16), 32'h1234_562A);
      wr(ad(8'h9F), 32'h0080_0003);
      hit(2, 32'h1234_562A, 3'h7, 1'b0, 0);
      hit(2, 32'h1234_562B, 3'h7, 1'b0, 1);
      rd(ad(8'hA0), 32'h7);
      chk_irq(1'b0);
      wr(ad(8'hA1), 32'h2);
      rd(ad(8'hA1), 32'h2);
      chk_irq(1'b1);
      wr(ad(8'hA0), 32'h2);
      chk_irq(1'b0);
      rd(ad(8'hA0), 32'h5);
      wr(ad(8'h15), 32'hFFFF_FFFF);
      rd(ad(8'h15), DBWU_CAUSE_WMASK);
      r = $urandom;
      wr(ad(8'h16), r);
      rd(ad(8'h16), r);
      repeat (2) @(posedge sys_clk);
      conclude();
   end
endmodule // tb

bind dbwu_top dbwu_top_sva i_dbwu_top_sva (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR),
   .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
   .FETCH_VALID(FETCH_VALID), .MEM_VALID(MEM_VALID), .RES_VALID(RES_VALID), .DEBUG_TRIGGER(DEBUG_TRIGGER), .IRQ(IRQ));

/* hdl/dbwu_pkg.sv */
// Constants, register indices and field layout of the debug breakpoint and watchpoint unit.
// Assumes one core clock, an AHB-Lite register port and a core that reports fetches and accesses each cycle.
//
// How it works
// - four instruction breakpoints, control registers at indices 0x40 to 0x43.
// - control bits 23:16 hold a per-thread enable mask for every unit.
// - control bit 0 enables the unit; all control fields reset to zero.
// - instruction control bit 1 picks fire on PC equal or PC different.
// - first 32-bit address for each data watchpoint, indices 0x50 to 0x53.
// - second 32-bit address for each data watchpoint, indices 0x60 to 0x63.
// - one control register per data watchpoint, indices 0x70 to 0x73.
// - data control bit 2 set lets load accesses trigger the watchpoint.
// - data control bit 1 combines conditions: 0 means A and B, 1 means A or B.
// - 32-bit mask per resource watchpoint, indices 0x80 to 0x83.
// - 32-bit compare value per resource watchpoint, indices 0x90 to 0x93.
// - one control register per resource watchpoint, indices 0x9C to 0x9F.
// - resource control bit 1 picks condition A at 0, condition B at 1.
// - 32-bit address per instruction breakpoint; enabled match raises a debug interrupt when mask bit 0 is set.
// - cause code recorded: 3 instruction, 4 data, 5 resource watchpoint.
// - number of the triggering unit recorded; lowest number wins on a tie.
// - effective address captured on data hits, resource identifier on resource hits.

package dbwu_pkg;

   // ************************************************************
   // Register indices; byte address is four times the index
   // ************************************************************
   localparam logic [7:0] DBWU_IDX_IB_ADDR  = 8'h30;
   localparam logic [7:0] DBWU_IDX_IB_CTRL  = 8'h40;
   localparam logic [7:0] DBWU_IDX_DW_FIRST = 8'h50;
   localparam logic [7:0] DBWU_IDX_DW_SEC   = 8'h60;
   localparam logic [7:0] DBWU_IDX_DW_CTRL  = 8'h70;
   localparam logic [7:0] DBWU_IDX_RW_MASK  = 8'h80;
   localparam logic [7:0] DBWU_IDX_RW_VALUE = 8'h90;
   localparam logic [7:0] DBWU_IDX_RW_CTRL  = 8'h9C;
   localparam logic [7:0] DBWU_IDX_CAUSE    = 8'h15;
   localparam logic [7:0] DBWU_IDX_DATA     = 8'h16;
   localparam logic [7:0] DBWU_IDX_STATUS   = 8'hA0;
   localparam logic [7:0] DBWU_IDX_MASK     = 8'hA1;

   // ************************************************************
   // Field layout
   // ************************************************************
   localparam int         DBWU_UNITS      = 4;
   localparam int         DBWU_THREADS    = 8;
   localparam int         DBWU_TMASK_LSB  = 16;
   localparam int         DBWU_BIT_EN     = 0;
   localparam int         DBWU_BIT_SENSE  = 1;
   localparam int         DBWU_BIT_LOAD   = 2;
   localparam logic [31:0] DBWU_IB_CTRL_WMASK = 32'h00FF0003;
   localparam logic [31:0] DBWU_DW_CTRL_WMASK = 32'h00FF0007;
   localparam logic [31:0] DBWU_RW_CTRL_WMASK = 32'h00FF0003;
   localparam logic [31:0] DBWU_CAUSE_WMASK   = 32'h0003FF07;
   localparam int         DBWU_CAUSE_NUM_LSB = 16;
   localparam int         DBWU_CAUSE_THR_LSB = 8;
   localparam logic [31:0] DBWU_RESET_ZERO    = 32'h00000000;

   // ************************************************************
   // Cause codes and event status bits
   // ************************************************************
   localparam logic [2:0] DBWU_CAUSE_IBREAK = 3'h3;
   localparam logic [2:0] DBWU_CAUSE_DWATCH = 3'h4;
   localparam logic [2:0] DBWU_CAUSE_RWATCH = 3'h5;
   localparam int         DBWU_EVT_IB       = 0;
   localparam int         DBWU_EVT_DW       = 1;
   localparam int         DBWU_EVT_RW       = 2;
   localparam int         DBWU_EVT_W        = 3;

   localparam logic [1:0] DBWU_HTRANS_NONSEQ = 2'h2;

endpackage : dbwu_pkg

/* hdl/dbwu_top.sv */
// Debug breakpoint and watchpoint unit: register file on AHB-Lite and the match logic.
// Assumes the core reports fetches, memory accesses and resource accesses on SYS_CLK, one per cycle.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/100ps

module dbwu_top (
   input  wire logic                 SYS_CLK,
   input  wire logic                 RESET_N,
   input  wire logic                 HSEL,
   input  wire logic [31:0]          HADDR,
   input  wire logic [1:0]           HTRANS,
   input  wire logic                 HWRITE,
   input  wire logic [2:0]           HSIZE,
   input  wire logic [31:0]          HWDATA,
   input  wire logic                 HREADY,
   output logic      [31:0]          HRDATA,
   output logic                      HREADYOUT,
   output logic                      HRESP,
   input  wire logic                 FETCH_VALID,
   input  wire logic [31:0]          FETCH_PC,
   input  wire logic [2:0]           FETCH_THREAD,
   input  wire logic                 MEM_VALID,
   input  wire logic [31:0]          MEM_ADDR,
   input  wire logic                 MEM_LOAD,
   input  wire logic [2:0]           MEM_THREAD,
   input  wire logic                 RES_VALID,
   input  wire logic [31:0]          RES_ID,
   input  wire logic [2:0]           RES_THREAD,
   output logic                      DEBUG_TRIGGER,
   output logic                      IRQ
);
   import dbwu_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [DBWU_UNITS-1:0][31:0] ib_addr;
      logic [DBWU_UNITS-1:0][31:0] ib_ctrl;
      logic [DBWU_UNITS-1:0][31:0] dw_first;
      logic [DBWU_UNITS-1:0][31:0] dw_second;
      logic [DBWU_UNITS-1:0][31:0] dw_ctrl;
      logic [DBWU_UNITS-1:0][31:0] rw_mask;
      logic [DBWU_UNITS-1:0][31:0] rw_value;
      logic [DBWU_UNITS-1:0][31:0] rw_ctrl;
      logic [31:0]                 cause;
      logic [31:0]                 data;
      logic [DBWU_EVT_W-1:0]       status;
      logic [DBWU_EVT_W-1:0]       mask;
      logic                        wr_pend;
      logic [7:0]                  wr_idx;
      logic [31:0]                 rdata;
      logic                        trigger;
   } dbwu_state_t;

   dbwu_state_t st;
   dbwu_state_t next_st;

   logic [DBWU_UNITS-1:0] ib_hit;
   logic [DBWU_UNITS-1:0] dw_hit;
   logic [DBWU_UNITS-1:0] rw_hit;

   // ************************************************************
   // Per-unit match logic
   // ************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < DBWU_UNITS; gi++) begin : g_unit
         logic                    ib_eq;
         logic [DBWU_THREADS-1:0] ib_tmask;
         logic                    dw_a;
         logic                    dw_b;
         logic                    dw_cond;
         logic [DBWU_THREADS-1:0] dw_tmask;
         logic                    rw_a;
         logic                    rw_b;
         logic [DBWU_THREADS-1:0] rw_tmask;

         assign ib_tmask = st.ib_ctrl[gi][DBWU_TMASK_LSB +: DBWU_THREADS];
         assign dw_tmask = st.dw_ctrl[gi][DBWU_TMASK_LSB +: DBWU_THREADS];
         assign rw_tmask = st.rw_ctrl[gi][DBWU_TMASK_LSB +: DBWU_THREADS];

         assign ib_eq = (FETCH_PC == st.ib_addr[gi]);
         // thread mask gating, enable bit, compare sense
         assign ib_hit[gi] = FETCH_VALID && st.ib_ctrl[gi][DBWU_BIT_EN]
                             && ib_tmask[FETCH_THREAD]
                             && (st.ib_ctrl[gi][DBWU_BIT_SENSE] ? !ib_eq : ib_eq);

         // conditions A and B from the two addresses
         assign dw_a = (MEM_ADDR == st.dw_first[gi]);
         assign dw_b = (MEM_ADDR == st.dw_second[gi]);
         assign dw_cond = st.dw_ctrl[gi][DBWU_BIT_SENSE] ? (dw_a || dw_b) : (dw_a && dw_b);
         // loads only trigger when enabled; stores always qualify
         assign dw_hit[gi] = MEM_VALID && st.dw_ctrl[gi][DBWU_BIT_EN]
                             && dw_tmask[MEM_THREAD]
                             && (!MEM_LOAD || st.dw_ctrl[gi][DBWU_BIT_LOAD]) && dw_cond;

         // masked identifier against the value; B is taken as the mismatch
         assign rw_a = ((RES_ID & st.rw_mask[gi]) == (st.rw_value[gi] & st.rw_mask[gi]));
         assign rw_b = !rw_a;
         assign rw_hit[gi] = RES_VALID && st.rw_ctrl[gi][DBWU_BIT_EN]
                             && rw_tmask[RES_THREAD]
                             && (st.rw_ctrl[gi][DBWU_BIT_SENSE] ? rw_b : rw_a);
      end
   endgenerate

   // Lowest set unit wins
   function automatic logic [1:0] dbwu_lowest(input logic [DBWU_UNITS-1:0] v);
      logic [1:0] r;
      r = 2'h0;
      for (int k = DBWU_UNITS - 1; k >= 0; k--) begin
         if (v[k]) begin
            r = 2'(k);
         end
      end
      return r;
   endfunction

   // Cause word: code in the low bits, thread and unit number above it
   function automatic logic [31:0] dbwu_cause(input logic [2:0] code,
                                              input logic [1:0] unit,
                                              input logic [2:0] thread);
      logic [31:0] c;
      c = 32'(code);
      c[DBWU_CAUSE_THR_LSB +: 3] = thread;
      c[DBWU_CAUSE_NUM_LSB +: 2] = unit;
      return c;
   endfunction

   // Read mux over the already-updated state, so a read right after a write sees it
   function automatic logic [31:0] dbwu_read(input dbwu_state_t s, input logic [7:0] idx);
      logic [31:0] r;
      logic [1:0]  u;
      r = DBWU_RESET_ZERO;
      u = idx[1:0];
      case ({idx[7:2], 2'h0})
         DBWU_IDX_IB_ADDR:  r = s.ib_addr[u];
         DBWU_IDX_IB_CTRL:  r = s.ib_ctrl[u];
         DBWU_IDX_DW_FIRST: r = s.dw_first[u];
         DBWU_IDX_DW_SEC:   r = s.dw_second[u];
         DBWU_IDX_DW_CTRL:  r = s.dw_ctrl[u];
         DBWU_IDX_RW_MASK:  r = s.rw_mask[u];
         DBWU_IDX_RW_VALUE: r = s.rw_value[u];
         DBWU_IDX_RW_CTRL:  r = s.rw_ctrl[u];
         default:           r = DBWU_RESET_ZERO;
      endcase
      if (idx == DBWU_IDX_CAUSE) begin
         r = s.cause;
      end
      if (idx == DBWU_IDX_DATA) begin
         r = s.data;
      end
      if (idx == DBWU_IDX_STATUS) begin
         r = {29'h0, s.status};
      end
      if (idx == DBWU_IDX_MASK) begin
         r = {29'h0, s.mask};
      end
      return r;
   endfunction

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      logic [1:0]             u;
      logic                   addr_ok;
      logic                   take;
      logic [DBWU_EVT_W-1:0]  evt;
      logic [DBWU_EVT_W-1:0]  clr;
      next_st = st;
      u       = st.wr_idx[1:0];
      addr_ok = (HADDR[31:10] == 22'h0);
      take    = HSEL && HREADY && (HTRANS == DBWU_HTRANS_NONSEQ);
      clr     = '0;
      evt     = {|rw_hit, |dw_hit, |ib_hit};

      // Write data phase
      if (st.wr_pend) begin
         case ({st.wr_idx[7:2], 2'h0})
            DBWU_IDX_IB_ADDR:  next_st.ib_addr[u]   = HWDATA;
            DBWU_IDX_IB_CTRL:  next_st.ib_ctrl[u]   = HWDATA & DBWU_IB_CTRL_WMASK;
            DBWU_IDX_DW_FIRST: next_st.dw_first[u]  = HWDATA;
            DBWU_IDX_DW_SEC:   next_st.dw_second[u] = HWDATA;
            DBWU_IDX_DW_CTRL:  next_st.dw_ctrl[u]   = HWDATA & DBWU_DW_CTRL_WMASK;
            DBWU_IDX_RW_MASK:  next_st.rw_mask[u]   = HWDATA;
            DBWU_IDX_RW_VALUE: next_st.rw_value[u]  = HWDATA;
            DBWU_IDX_RW_CTRL:  next_st.rw_ctrl[u]   = HWDATA & DBWU_RW_CTRL_WMASK;
            default: begin
            end
         endcase
         if (st.wr_idx == DBWU_IDX_CAUSE) begin
            next_st.cause = HWDATA & DBWU_CAUSE_WMASK;
         end
         if (st.wr_idx == DBWU_IDX_DATA) begin
            next_st.data = HWDATA;
         end
         if (st.wr_idx == DBWU_IDX_STATUS) begin
            clr = HWDATA[DBWU_EVT_W-1:0];
         end
         if (st.wr_idx == DBWU_IDX_MASK) begin
            next_st.mask = HWDATA[DBWU_EVT_W-1:0];
         end
      end

      // Trigger capture; instruction beats data beats resource in one cycle
      next_st.trigger = |evt;
      if (evt[DBWU_EVT_IB]) begin
         next_st.cause = dbwu_cause(DBWU_CAUSE_IBREAK, dbwu_lowest(ib_hit), FETCH_THREAD);
      end else if (evt[DBWU_EVT_DW]) begin
         next_st.cause = dbwu_cause(DBWU_CAUSE_DWATCH, dbwu_lowest(dw_hit), MEM_THREAD);
         next_st.data  = MEM_ADDR;
      end else if (evt[DBWU_EVT_RW]) begin
         next_st.cause = dbwu_cause(DBWU_CAUSE_RWATCH, dbwu_lowest(rw_hit), RES_THREAD);
         next_st.data  = RES_ID;
      end
      // Set wins over write-one-to-clear
      next_st.status = (st.status & ~clr) | evt;

      // Address phase
      next_st.wr_pend = take && HWRITE && addr_ok;
      next_st.wr_idx  = HADDR[9:2];
      if (take && !HWRITE) begin
         next_st.rdata = addr_ok ? dbwu_read(next_st, HADDR[9:2]) : DBWU_RESET_ZERO;
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign HRDATA        = st.rdata;
   assign HREADYOUT     = 1'h1;
   assign HRESP         = 1'h0;
   assign DEBUG_TRIGGER = st.trigger;
   assign IRQ           = |(st.status & st.mask);

endmodule // dbwu_top
